/* File: hdl/pst_regs.svh */
`ifndef PST_REGS_SVH
`define PST_REGS_SVH

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define PST_ADDR_W 12
`define PST_TMR_AREA 4'h0
`define PST_SEL_CON 2'h0
`define PST_SEL_CNT 2'h1
`define PST_SEL_PER 2'h2
`define PST_SEL_NONE 2'h3
`define PST_OFS_STAT 12'h100
`define PST_OFS_MASK 12'h110
`define PST_AREA_MSB 11
`define PST_AREA_LSB 8
`define PST_IDX_MSB 7
`define PST_IDX_LSB 6
`define PST_SEL_MSB 5
`define PST_SEL_LSB 4
`define PST_OPC_MSB 3
`define PST_OPC_LSB 2
`define PST_ALIGN_MSB 1
`define PST_ALIGN_OK 2'h0
`define PST_HALF_MSB 15
`define PST_FLAG_MSB 3

// ----------------------------------------------------------------
// control field positions
// ----------------------------------------------------------------
`define PST_ON_BIT 15
`define PST_SIDL_BIT 13
`define PST_GATE_BIT 7
`define PST_PS_MSB 6
`define PST_PS_LSB 4
`define PST_PAIR_BIT 3
`define PST_CSRC_BIT 1

// ----------------------------------------------------------------
// write masks and reset values
// ----------------------------------------------------------------
`define PST_CON_WMASK_EVEN 16'hA0FA
`define PST_CON_WMASK_ODD 16'hA0F2
`define PST_CON_RST 16'h0000
`define PST_CNT_RST 16'h0000
`define PST_PER_RST 16'hFFFF
`define PST_FLAG_RST 4'h0
`define PST_PRE_RST 8'h00

// ----------------------------------------------------------------
// prescaler terminal counts (divide by 1,2,4,8,16,32,64,256)
// ----------------------------------------------------------------
`define PST_PS_TC0 8'h00
`define PST_PS_TC1 8'h01
`define PST_PS_TC2 8'h03
`define PST_PS_TC3 8'h07
`define PST_PS_TC4 8'h0F
`define PST_PS_TC5 8'h1F
`define PST_PS_TC6 8'h3F
`define PST_PS_TC7 8'hFF

`endif

/* File: hdl/pst_pkg.sv */
package pst_pkg;
    typedef logic [31:0] pst_word_t;
    typedef logic [15:0] pst_half_t;
    typedef logic [11:0] pst_addr_t;
    typedef logic [3:0] pst_quad_t;
    typedef enum logic [1:0] {
        PST_OP_WR = 2'h0,
        PST_OP_CLR = 2'h1,
        PST_OP_SET = 2'h2,
        PST_OP_INV = 2'h3
    } pst_op_e;
endpackage

/* File: hdl/pst_tick.sv */
`timescale 1ns/10ps
`include "pst_regs.svh"
module pst_tick (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic pin_i,
    input wire logic run_i,
    input wire logic csrc_i,
    input wire logic gate_i,
    input wire logic [2:0] ps_i,
    output logic tick_o,
    output logic gate_fall_o
);
    import pst_pkg::*;

    // ----------------------------------------------------------------
    // pin synchroniser and prescaler
    // ----------------------------------------------------------------
    logic sync1_r, sync2_r, prev_r;
    logic [7:0] pre_r, pre_nxt;
    logic [7:0] tc;
    logic src_ev;

    always_comb begin
        case (ps_i)
            3'h0: tc = `PST_PS_TC0;
            3'h1: tc = `PST_PS_TC1;
            3'h2: tc = `PST_PS_TC2;
            3'h3: tc = `PST_PS_TC3;
            3'h4: tc = `PST_PS_TC4;
            3'h5: tc = `PST_PS_TC5;
            3'h6: tc = `PST_PS_TC6;
            default: tc = `PST_PS_TC7;
        endcase
        // external edge, gated internal, or plain internal clock
        if (csrc_i) begin
            src_ev = sync2_r & ~prev_r;
        end else if (gate_i) begin
            src_ev = sync2_r;
        end else begin
            src_ev = 1'b1;
        end
        pre_nxt = pre_r;
        tick_o = 1'b0;
        if (!run_i) begin
            pre_nxt = `PST_PRE_RST;
        end else if (src_ev) begin
            if (pre_r == tc) begin
                pre_nxt = `PST_PRE_RST;
                tick_o = 1'b1;
            end else begin
                pre_nxt = pre_r + 8'h01;
            end
        end
        // gate fall only counts as an event in gated internal mode
        gate_fall_o = run_i & gate_i & ~csrc_i & prev_r & ~sync2_r;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
            pre_r <= `PST_PRE_RST;
        end else begin
            sync1_r <= pin_i;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
            pre_r <= pre_nxt;
        end
    end
endmodule

/* File: hdl/pst_top.sv */
// Local design decisions: the address map and the APB register port.
`timescale 1ns/10ps
`include "pst_regs.svh"
// Summary of operation
// - four independent 16-bit timers or event counters
// - internal, gated and external clock modes
// - second/third and fourth/fifth pair into 32-bit
// - paired timers keep the same three modes
// - pair driven by even timer's control; odd idle stop also stops it
// - timers keep counting in idle unless stopped
// - only second/third timers feed capture/compare
// - converter trigger from third timer or pair
// - clear, set, invert aliases per timer register
// - pair select bit joins even and odd
// - clock source: pin edges or internal clock
// - pair bit even-only; odd source ignored paired
module pst_top (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire pst_pkg::pst_addr_t PADDR_I,
    input wire pst_pkg::pst_word_t PWDATA_I,
    output pst_pkg::pst_word_t PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire pst_pkg::pst_quad_t TMR_PIN_I,
    input wire logic IDLE_I,
    output logic IRQ_O,
    output pst_pkg::pst_half_t TB_A_CNT_O,
    output pst_pkg::pst_half_t TB_B_CNT_O,
    output logic TB_PAIR_O,
    output logic ADC_TRIG_O
);
    import pst_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pst_half_t con_r [4];
    pst_half_t cnt_r [4];
    pst_half_t per_r [4];
    pst_half_t con_nxt [4];
    pst_half_t cnt_nxt [4];
    pst_half_t per_nxt [4];
    pst_quad_t stat_r, stat_nxt;
    pst_quad_t mask_r, mask_nxt;
    pst_word_t rdata_r, rdata_nxt;
    logic trig_r, trig_nxt;

    pst_quad_t tick;
    pst_quad_t gfall;
    pst_quad_t run;
    pst_quad_t ev;
    logic [1:0] paired;
    logic [1:0] pair_match;
    logic [1:0] match16;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    logic [1:0] idx;
    logic [1:0] sel;
    pst_op_e op;
    logic hit_tmr, hit_stat, hit_mask, hit;
    logic acc, wr, rd_stat;
    pst_half_t wd16;

    assign idx = PADDR_I[`PST_IDX_MSB:`PST_IDX_LSB];
    assign sel = PADDR_I[`PST_SEL_MSB:`PST_SEL_LSB];
    assign op = pst_op_e'(PADDR_I[`PST_OPC_MSB:`PST_OPC_LSB]);
    assign wd16 = PWDATA_I[`PST_HALF_MSB:0];
    assign hit_tmr = (PADDR_I[`PST_AREA_MSB:`PST_AREA_LSB] == `PST_TMR_AREA)
        && (sel != `PST_SEL_NONE) && (PADDR_I[`PST_ALIGN_MSB:0] == `PST_ALIGN_OK);
    assign hit_stat = (PADDR_I == `PST_OFS_STAT);
    assign hit_mask = (PADDR_I == `PST_OFS_MASK);
    assign hit = hit_tmr | hit_stat | hit_mask;
    assign acc = PSEL_I & PENABLE_I;
    assign wr = acc & PWRITE_I & hit;
    assign rd_stat = acc & ~PWRITE_I & hit_stat;

    // zero wait states; read data is captured in the setup cycle
    assign PREADY_O = 1'b1;
    assign PSLVERR_O = acc & ~hit;
    assign PRDATA_O = rdata_r;

    function automatic pst_half_t alias_apply(input pst_half_t old, input pst_half_t wd,
                                              input pst_op_e o);
        pst_half_t res;
        res = old;
        case (o)
            PST_OP_WR: res = wd;
            PST_OP_CLR: res = old & ~wd;
            PST_OP_SET: res = old | wd;
            PST_OP_INV: res = old ^ wd;
            default: res = old;
        endcase
        return res;
    endfunction

    // ----------------------------------------------------------------
    // per-timer clock conditioning
    // ----------------------------------------------------------------
    always_comb begin
        for (int k = 0; k < 2; k++) begin
            paired[k] = con_r[2 * k][`PST_PAIR_BIT];
            // paired: odd idle stop also honoured, so software must clear it
            run[2 * k] = con_r[2 * k][`PST_ON_BIT] & ~(IDLE_I
                & (con_r[2 * k][`PST_SIDL_BIT]
                | (paired[k] & con_r[2 * k + 1][`PST_SIDL_BIT])));
            // odd half is clocked by the even unit while paired
            run[2 * k + 1] = ~paired[k] & con_r[2 * k + 1][`PST_ON_BIT]
                & ~(IDLE_I & con_r[2 * k + 1][`PST_SIDL_BIT]);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_tick
            pst_tick u_tick (
                .clk_i(CLK_I),
                .nrst_i(NRST_I),
                .pin_i(TMR_PIN_I[g]),
                .run_i(run[g]),
                .csrc_i(con_r[g][`PST_CSRC_BIT]),
                .gate_i(con_r[g][`PST_GATE_BIT]),
                .ps_i(con_r[g][`PST_PS_MSB:`PST_PS_LSB]),
                .tick_o(tick[g]),
                .gate_fall_o(gfall[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    always_comb begin
        logic [31:0] cnt32;
        logic [31:0] per32;
        logic [31:0] inc32;
        int e;
        int o;
        cnt32 = 32'h0000_0000;
        per32 = 32'h0000_0000;
        inc32 = 32'h0000_0000;
        e = 0;
        o = 0;
        ev = `PST_FLAG_RST;
        pair_match = 2'h0;
        match16 = 2'h0;
        for (int i = 0; i < 4; i++) begin
            cnt_nxt[i] = cnt_r[i];
        end
        for (int k = 0; k < 2; k++) begin
            e = 2 * k;
            o = 2 * k + 1;
            cnt32 = {cnt_r[o], cnt_r[e]};
            per32 = {per_r[o], per_r[e]};
            inc32 = cnt32 + 32'h0000_0001;
            if (paired[k]) begin
                // upper half flags the pair, as the odd timer would
                if (tick[e]) begin
                    if (cnt32 == per32) begin
                        cnt_nxt[e] = `PST_CNT_RST;
                        cnt_nxt[o] = `PST_CNT_RST;
                        pair_match[k] = 1'b1;
                    end else begin
                        cnt_nxt[e] = inc32[15:0];
                        cnt_nxt[o] = inc32[31:16];
                    end
                end
                ev[o] = (pair_match[k] & ~con_r[e][`PST_GATE_BIT]) | gfall[e];
            end else begin
                for (int j = 0; j < 2; j++) begin
                    if (tick[e + j]) begin
                        if (cnt_r[e + j] == per_r[e + j]) begin
                            cnt_nxt[e + j] = `PST_CNT_RST;
                            if (j == 1) begin
                                match16[k] = 1'b1;
                            end
                            ev[e + j] = ~con_r[e + j][`PST_GATE_BIT];
                        end else begin
                            cnt_nxt[e + j] = cnt_r[e + j] + 16'h0001;
                        end
                    end
                    if (gfall[e + j]) begin
                        ev[e + j] = 1'b1;
                    end
                end
            end
        end
        // software writes to a count take priority over counting
        if (wr && hit_tmr && (sel == `PST_SEL_CNT)) begin
            cnt_nxt[idx] = alias_apply(cnt_r[idx], wd16, op);
        end
    end

    // ----------------------------------------------------------------
    // control, period, status and mask
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            con_nxt[i] = con_r[i];
            per_nxt[i] = per_r[i];
        end
        mask_nxt = mask_r;
        if (wr && hit_tmr && (sel == `PST_SEL_CON)) begin
            // pair bit is writable on even timers only
            if (idx[0]) begin
                con_nxt[idx] = alias_apply(con_r[idx], wd16, op)
                    & `PST_CON_WMASK_ODD;
            end else begin
                con_nxt[idx] = alias_apply(con_r[idx], wd16, op)
                    & `PST_CON_WMASK_EVEN;
            end
        end
        if (wr && hit_tmr && (sel == `PST_SEL_PER)) begin
            per_nxt[idx] = alias_apply(per_r[idx], wd16, op);
        end
        if (wr && hit_mask) begin
            mask_nxt = PWDATA_I[`PST_FLAG_MSB:0];
        end
        // read clears only bits it returned, so late events are not lost
        stat_nxt = (stat_r & ~(rd_stat ? rdata_r[`PST_FLAG_MSB:0] : `PST_FLAG_RST)) | ev;
        // converter trigger from third timer, or the low pair when joined
        trig_nxt = paired[0] ? pair_match[0] : match16[0];
    end

    // ----------------------------------------------------------------
    // read mux, sampled in the setup cycle
    // ----------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        if (PSEL_I && !PENABLE_I) begin
            rdata_nxt = 32'h0000_0000;
            if (!PWRITE_I && hit_tmr) begin
                case (sel)
                    `PST_SEL_CON: rdata_nxt = {16'h0000, con_r[idx]};
                    `PST_SEL_CNT: rdata_nxt = {16'h0000, cnt_r[idx]};
                    `PST_SEL_PER: rdata_nxt = {16'h0000, per_r[idx]};
                    default: rdata_nxt = 32'h0000_0000;
                endcase
            end else if (!PWRITE_I && hit_stat) begin
                rdata_nxt = {28'h000_0000, stat_r};
            end else if (!PWRITE_I && hit_mask) begin
                rdata_nxt = {28'h000_0000, mask_r};
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!NRST_I) begin
            for (int i = 0; i < 4; i++) begin
                con_r[i] <= `PST_CON_RST;
                cnt_r[i] <= `PST_CNT_RST;
                per_r[i] <= `PST_PER_RST;
            end
            stat_r <= `PST_FLAG_RST;
            mask_r <= `PST_FLAG_RST;
            rdata_r <= 32'h0000_0000;
            trig_r <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                con_r[i] <= con_nxt[i];
                cnt_r[i] <= cnt_nxt[i];
                per_r[i] <= per_nxt[i];
            end
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
            trig_r <= trig_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign IRQ_O = |(stat_r & mask_r);
    // capture/compare time base only from the low pair
    assign TB_A_CNT_O = cnt_r[0];
    assign TB_B_CNT_O = cnt_r[1];
    assign TB_PAIR_O = con_r[0][`PST_PAIR_BIT];
    assign ADC_TRIG_O = trig_r;
endmodule

/* File: verif/pst_pin_src.sv */
`timescale 1ns/10ps
// ----------------------------------------
// external clock and gate pin source
// ----------------------------------------
module pst_pin_src (
    input wire logic clk_i,
    input wire logic [3:0] run_i,
    input wire logic [3:0] lvl_i,
    output logic [3:0] pin_o
);
    logic [3:0] tog_r = 4'h0;
    // free toggling only while run; a stopped pin stands at lvl
    always_ff @(posedge clk_i) begin
        tog_r <= tog_r ^ run_i;
    end
    assign pin_o = (run_i & tog_r) | (~run_i & lvl_i);
endmodule

/* File: verif/pst_chk.sv */
`timescale 1ns/10ps
// ----------------------------------------
// port checker
// ----------------------------------------
module pst_chk (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire pst_pkg::pst_addr_t PADDR_I,
    input wire pst_pkg::pst_word_t PRDATA_O,
    input wire logic PREADY_O,
    input wire logic PSLVERR_O,
    input wire logic IRQ_O,
    input wire pst_pkg::pst_half_t TB_A_CNT_O,
    input wire pst_pkg::pst_half_t TB_B_CNT_O,
    input wire logic TB_PAIR_O,
    input wire logic ADC_TRIG_O
);
    import pst_pkg::*;
    logic acc, wr_a, wr_b, mapd, irq_acc;
    assign acc = PSEL_I && PENABLE_I;
    assign wr_a = acc && PWRITE_I && PADDR_I[11:4] == 8'h01;
    assign wr_b = acc && PWRITE_I && PADDR_I[11:4] == 8'h05;
    assign mapd = (PADDR_I < 12'h100 && PADDR_I[5:4] != 2'h3 && PADDR_I[1:0] == 2'h0)
        || PADDR_I == 12'h100 || PADDR_I == 12'h110;
    assign irq_acc = acc && (PWRITE_I ? PADDR_I == 12'h110 : PADDR_I == 12'h100);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);
    sequence s_setup;
        PSEL_I && !PENABLE_I;
    endsequence
    sequence s_access;
        s_setup ##1 acc;
    endsequence
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_ready_now: assert property (s_access |-> PREADY_O)
        else $error("access not ready");
    a_err_map: assert property (PSLVERR_O == (acc && !mapd))
        else $error("error flag wrong");
    a_rdata_hold: assert property (!PSEL_I |=> $stable(PRDATA_O))
        else $error("read data moved while idle");
    a_cnt_a_step: assert property ($changed(TB_A_CNT_O) && !$past(wr_a) |->
        TB_A_CNT_O == $past(TB_A_CNT_O) + 16'h0001 || TB_A_CNT_O == 16'h0000)
        else $error("timer a bad step");
    a_cnt_b_step: assert property ($changed(TB_B_CNT_O) && !$past(wr_b) |->
        TB_B_CNT_O == $past(TB_B_CNT_O) + 16'h0001 || TB_B_CNT_O == 16'h0000)
        else $error("timer b bad step");
    // pulse follows the wrap edge, so the wrapped count stands beside it
    a_trig_wrap: assert property (ADC_TRIG_O |-> TB_B_CNT_O == 16'h0000
        && (!TB_PAIR_O || TB_A_CNT_O == 16'h0000))
        else $error("trigger without wrap");
    a_pair_write: assert property ($rose(TB_PAIR_O) |->
        $past(acc && PWRITE_I && PADDR_I[11:4] == 8'h00))
        else $error("pair bit set without write");
    a_irq_drop: assert property ($fell(IRQ_O) |-> !$past(NRST_I) || $past(irq_acc))
        else $error("interrupt dropped by itself");
endmodule

bind pst_top pst_chk u_chk (
    .CLK_I(CLK_I), .NRST_I(NRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .IRQ_O(IRQ_O), .TB_A_CNT_O(TB_A_CNT_O),
    .TB_B_CNT_O(TB_B_CNT_O), .TB_PAIR_O(TB_PAIR_O), .ADC_TRIG_O(ADC_TRIG_O)
);

/* File: verif/tb_paired_sync_timers.sv */
`timescale 1ns/10ps
module tb_paired_sync_timers;
    import pst_pkg::*;
    localparam pst_word_t ZW = 32'h0000_0000;
    localparam pst_word_t OW = 32'h0000_0001;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic idle = 1'b0;
    pst_addr_t addr = 12'h000;
    pst_word_t wdat = ZW;
    logic [3:0] run = 4'h0;
    logic [3:0] lvl = 4'h0;
    logic [3:0] pin;
    pst_word_t rdat, rd;
    logic rdy, err, irq, pair, trig, er;
    pst_half_t cnt_a, cnt_b;
    int num_errors = 0;
    int num_checks = 0;
    always #2.5 clk = ~clk;
    pst_top dut (
        .CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(addr), .PWDATA_I(wdat), .PRDATA_O(rdat), .PREADY_O(rdy), .PSLVERR_O(err),
        .TMR_PIN_I(pin), .IDLE_I(idle), .IRQ_O(irq), .TB_A_CNT_O(cnt_a),
        .TB_B_CNT_O(cnt_b), .TB_PAIR_O(pair), .ADC_TRIG_O(trig)
    );
    pst_pin_src u_src (.clk_i(clk), .run_i(run), .lvl_i(lvl), .pin_o(pin));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input pst_word_t got, input pst_word_t exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic rst();
        nrst <= 1'b0;
        run <= 4'h0;
        lvl <= 4'h0;
        idle <= 1'b0;
        cyc(8);
        nrst <= 1'b1;
        cyc(1);
    endtask
    // one idle edge after each transfer keeps strobes single-driven per step
    task automatic apb(input logic w, input pst_addr_t a, input pst_word_t d);
        int i;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= d;
        @(posedge clk);
        pen <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (rdy !== 1'b1 && i < 50);
        chk(32'(rdy), OW);
        if (rdy !== 1'b1) end_of_test();
        rd = rdat;
        er = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input pst_addr_t a, input pst_word_t d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input pst_addr_t a, input pst_word_t exp);
        apb(1'b0, a, ZW);
        chk(rd, exp);
    endtask
    // use_trig picks the watched output: 1 for the trigger, 0 for the interrupt
    task automatic wait_hi(input logic use_trig, input int n);
        int i;
        i = 0;
        while ((use_trig ? trig : irq) !== 1'b1 && i < n) begin
            @(posedge clk);
            i++;
        end
        chk(32'(use_trig ? trig : irq), OW);
        if ((use_trig ? trig : irq) !== 1'b1) end_of_test();
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        rdc(12'h000, ZW);
        rdc(12'h020, 32'h0000_FFFF);
        wr(12'h020, 32'h0000_1234);
        wr(12'h028, 32'h0000_00F0);
        rdc(12'h020, 32'h0000_12F4);
        wr(12'h024, 32'h0000_0004);
        rdc(12'h020, 32'h0000_12F0);
        wr(12'h02C, 32'h0000_000F);
        rdc(12'h020, 32'h0000_12FF);
        wr(12'h040, 32'h0000_000A);
        rdc(12'h040, 32'h0000_0002);
        apb(1'b0, 12'h0F0, ZW);
        chk(32'(er), OW);
    endtask
    task automatic t_int();
        wr(12'h110, OW);
        wr(12'h020, 32'h0000_0003);
        wr(12'h000, 32'h0000_8000);
        wait_hi(1'b0, 20);
        wr(12'h000, ZW);
        chk(32'(cnt_a <= 16'h0003), OW);
        rdc(12'h100, OW);
        chk(32'(irq), ZW);
    endtask
    task automatic t_ext();
        wr(12'h040, 32'h0000_8002);
        repeat (5) begin
            lvl <= 4'h2;
            cyc(4);
            lvl <= 4'h0;
            cyc(4);
        end
        chk({16'h0000, cnt_b}, 32'h0000_0005);
    endtask
    task automatic t_gate();
        wr(12'h110, OW);
        wr(12'h000, 32'h0000_8080);
        cyc(4);
        chk({16'h0000, cnt_a}, ZW);
        lvl <= 4'h1;
        cyc(20);
        lvl <= 4'h0;
        cyc(4);
        // twenty gate-high cycles, the synchroniser delays both edges alike
        chk({16'h0000, cnt_a}, 32'h0000_0014);
        rdc(12'h100, OW);
    endtask
    // carry from the lower into the upper half before the 32-bit match
    task automatic t_pair();
        pst_half_t v;
        wr(12'h110, 32'h0000_0002);
        // odd idle stop kept clear while paired
        wr(12'h040, 32'h0000_0002);
        wr(12'h010, 32'h0000_FFFE);
        wr(12'h020, ZW);
        wr(12'h060, OW);
        wr(12'h000, 32'h0000_8008);
        chk(32'(pair), OW);
        wait_hi(1'b1, 20);
        rdc(12'h100, 32'h0000_0002);
        idle <= 1'b1;
        v = cnt_a;
        cyc(4);
        chk({16'h0000, 16'(cnt_a - v)}, 32'h0000_0004);
    endtask
    task automatic t_idle();
        idle <= 1'b1;
        wr(12'h080, 32'h0000_8000);
        wr(12'h000, 32'h0000_A000);
        cyc(10);
        chk({16'h0000, cnt_a}, ZW);
        wr(12'h000, 32'h0000_8000);
        cyc(10);
        chk(32'(cnt_a != 16'h0000), OW);
        // fourth timer ran on its own through all of the above
        rdc(12'h090, 32'h0000_001B);
    endtask
    task automatic t_trig();
        wr(12'h060, 32'h0000_0003);
        wr(12'h040, 32'h0000_8002);
        run <= 4'h2;
        wait_hi(1'b1, 40);
    endtask
    initial begin
        rst();
        t_regs();
        rst();
        t_int();
        rst();
        t_ext();
        rst();
        t_gate();
        rst();
        t_pair();
        rst();
        t_idle();
        rst();
        t_trig();
        end_of_test();
    end
endmodule
